// file: rtl/cpu_biu_pkg.sv
`default_nettype none

package cpu_biu_pkg;

    // ----------------------------------------
    // address formation
    // ----------------------------------------
    localparam int ADDR_W = 20;
    localparam int OFF_W = 16;
    localparam int SEG_SHIFT = 4;
    localparam int BYTE_W = 8;

    // ----------------------------------------
    // variant shape
    // ----------------------------------------
    localparam int WIDE_DATA_W = 16;
    localparam int NARROW_DATA_W = 8;
    localparam int WIDE_QUEUE_BYTES = 6;
    localparam int NARROW_QUEUE_BYTES = 4;
    localparam int WIDE_FETCH_FREE = 2;
    localparam int NARROW_FETCH_FREE = 1;
    localparam int RESP_DEPTH = 2;

    // ----------------------------------------
    // segment register selectors and reset values
    // ----------------------------------------
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_STACK = 2'h1;
    localparam logic [1:0] SEG_CODE = 2'h2;
    localparam logic [1:0] SEG_DATA = 2'h3;
    localparam logic [15:0] SEG_RESET = 16'h0000;
    localparam logic [15:0] IP_RESET = 16'h0000;

    // ----------------------------------------
    // bus cycle states: T1..T4 with waits between T3 and T4
    // ----------------------------------------
    typedef enum logic [2:0] {
        T_IDLE  = 3'b000,
        T_ONE   = 3'b001,
        T_TWO   = 3'b010,
        T_THREE = 3'b011,
        T_WAIT  = 3'b100,
        T_FOUR  = 3'b101
    } bus_state_type;

    // ----------------------------------------
    // maximum-mode cycle status codes
    // ----------------------------------------
    localparam logic [2:0] STAT_IO_READ = 3'h1;
    localparam logic [2:0] STAT_IO_WRITE = 3'h2;
    localparam logic [2:0] STAT_CODE = 3'h4;
    localparam logic [2:0] STAT_MEM_READ = 3'h5;
    localparam logic [2:0] STAT_MEM_WRITE = 3'h6;
    localparam logic [2:0] STAT_PASSIVE = 3'h7;

    // ----------------------------------------
    // queue status codes
    // ----------------------------------------
    localparam logic [1:0] QST_NONE = 2'h0;
    localparam logic [1:0] QST_TAKEN = 2'h1;
    localparam logic [1:0] QST_FLUSH = 2'h2;

endpackage

`default_nettype wire

// file: rtl/bus_interface_unit.sv
// Functional notes
// - physical addresses are 20 bits wide, one megabyte, in both variants.
// - external data path is 16 bits wide variant, 8 bits narrow.
// - prefetch queue holds six bytes wide, four bytes narrow.
// - address and data share the same pins at different times.
// - strap high selects minimum mode; device generates bus controls.
// - maximum mode stops driving minimum-mode controls; external controller commands.
// - minimum-mode pin set applies while strap is at supply level.
// - execution unit takes bytes from queue head, stalls when empty.
// - execution unit memory and I/O accesses go through bus requests.
// - dedicated adder forms addresses; unit holds segments and instruction pointer.
// - wide fetch starts when two bytes free and no request pending.
// - narrow fetch starts as soon as one queue byte is free.
// - a fetch loads two bytes wide from an even address, one byte from an odd address or narrow.
// - a running fetch cycle completes before a request is served.
// - every bus cycle lasts at least four states; address in first.
// - a jump discards the queue and restarts fetching at the target.
// - idle states are inserted when nothing needs the bus.
`default_nettype none

module bus_interface_unit #(
    parameter bit WIDE = 1'b1,
    parameter int DATA_W = WIDE ? cpu_biu_pkg::WIDE_DATA_W : cpu_biu_pkg::NARROW_DATA_W,
    parameter int QUEUE_BYTES = WIDE ? cpu_biu_pkg::WIDE_QUEUE_BYTES : cpu_biu_pkg::NARROW_QUEUE_BYTES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // strap and wait control pins
    input wire logic mode_strap_i,
    input wire logic ready_i,
    // segment register writes and jumps from the execution unit
    input wire logic seg_wr_i,
    input wire logic [1:0] seg_wr_sel_i,
    input wire logic [15:0] seg_wr_data_i,
    input wire logic jump_i,
    input wire logic [15:0] jump_seg_i,
    input wire logic [15:0] jump_off_i,
    // code byte stream to the execution unit
    output logic code_valid_o,
    output logic [7:0] code_byte_o,
    input wire logic code_ready_i,
    // execution unit bus requests
    input wire logic eu_req_valid_i,
    output logic eu_req_ready_o,
    input wire logic eu_req_write_i,
    input wire logic eu_req_io_i,
    input wire logic eu_req_word_i,
    input wire logic [1:0] eu_req_seg_i,
    input wire logic [15:0] eu_req_off_i,
    input wire logic [15:0] eu_req_wdata_i,
    // read data back to the execution unit
    output logic eu_rsp_valid_o,
    output logic [15:0] eu_rsp_rdata_o,
    input wire logic eu_rsp_ready_i,
    // multiplexed bus pins
    input wire logic [DATA_W-1:0] muxed_addr_data_i,
    output logic [DATA_W-1:0] muxed_addr_data_o,
    output logic muxed_addr_data_oe_n_o,
    output logic [7:0] addr_mid_o,
    output logic [3:0] high_addr_status_o,
    output logic high_byte_enable_status_n_o,
    // minimum-mode controls
    output logic min_ctl_oe_n_o,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic mem_io_o,
    output logic dt_r_o,
    output logic den_n_o,
    // maximum-mode status
    output logic [2:0] cycle_status_code_o,
    output logic [1:0] queue_state_out_o
);

    localparam int QPW = $clog2(QUEUE_BYTES);
    localparam int CW = $clog2(QUEUE_BYTES + 1);
    localparam logic [CW-1:0] QB = CW'(QUEUE_BYTES);
    localparam logic [CW-1:0] FETCH_FREE = WIDE ? CW'(cpu_biu_pkg::WIDE_FETCH_FREE)
                                                : CW'(cpu_biu_pkg::NARROW_FETCH_FREE);

    function automatic logic [cpu_biu_pkg::ADDR_W-1:0] phys_addr(input logic [15:0] seg, input logic [15:0] off);
        phys_addr = {seg, 4'h0} + {4'h0, off};
    endfunction

    function automatic logic [QPW-1:0] ptr_inc(input logic [QPW-1:0] p);
        ptr_inc = (p == QPW'(QUEUE_BYTES - 1)) ? '0 : p + 1'b1;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] mode_sync_q;
    logic [2:0] ready_sync_q;
    logic mode_min_q;
    logic ready_q;

    // strap sampled continuously, board holds it fixed
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // preset to the reset-time levels so no false change shows after release
            mode_sync_q <= 3'h7;
            ready_sync_q <= 3'h7;
            mode_min_q <= 1'b1;
            ready_q <= 1'b1;
        end else begin
            mode_sync_q <= {mode_sync_q[1:0], mode_strap_i};
            ready_sync_q <= {ready_sync_q[1:0], ready_i};
            if (mode_sync_q[1] == mode_sync_q[2]) begin
                mode_min_q <= mode_sync_q[2];
            end
            if (ready_sync_q[1] == ready_sync_q[2]) begin
                ready_q <= ready_sync_q[2];
            end
        end
    end

    // ----------------------------------------
    // state and declarations
    // ----------------------------------------
    cpu_biu_pkg::bus_state_type state_q;
    cpu_biu_pkg::bus_state_type state_d;
    logic [15:0] seg_q [4];
    logic [15:0] fetch_ip_q;
    logic [7:0] queue_q [QUEUE_BYTES];
    logic [QPW-1:0] q_wp_q;
    logic [QPW-1:0] q_rp_q;
    logic [CW-1:0] q_count_q;
    logic [CW-1:0] q_count_d;
    logic flush_q;
    logic cyc_fetch_q;
    logic cyc_write_q;
    logic cyc_io_q;
    logic cyc_both_q;
    logic [1:0] cyc_seg_q;
    logic [cpu_biu_pkg::ADDR_W-1:0] cyc_addr_q;
    logic [15:0] cyc_wdata_q;
    logic part_q;
    logic [7:0] rdata_lo_q;
    logic [1:0] qs_q;
    logic [15:0] rsp_q [cpu_biu_pkg::RESP_DEPTH];
    logic rsp_wp_q;
    logic rsp_rp_q;
    logic [1:0] rsp_count_q;

    logic boundary;
    logic eu_split;
    logic part_now;
    logic eu_done;
    logic start_eu;
    logic start_fetch;
    logic q_push;
    logic q_pop;
    logic rsp_push;
    logic rsp_pop;
    logic fetch_two;
    logic [15:0] eu_off;
    logic [cpu_biu_pkg::ADDR_W-1:0] eu_addr;
    logic [15:0] bus_in16;
    logic [7:0] lane_byte;
    logic [15:0] rsp_data;
    logic [15:0] eu_wdata_lanes;
    logic [CW-1:0] push_n;

    // ----------------------------------------
    // request arbitration
    // ----------------------------------------
    // 16-bit view of the data pins; narrow repeats its byte
    assign bus_in16 = {muxed_addr_data_i[DATA_W-1 -: 8], muxed_addr_data_i[7:0]};
    assign lane_byte = (WIDE && cyc_addr_q[0]) ? bus_in16[15:8] : bus_in16[7:0];

    // new cycles only start from idle or after T4
    assign boundary = (state_q == cpu_biu_pkg::T_IDLE) || (state_q == cpu_biu_pkg::T_FOUR);
    // words that straddle lanes, or any word on the narrow bus, take two byte cycles
    assign eu_split = eu_req_word_i && (!WIDE || eu_req_off_i[0]);
    assign eu_done = (state_q == cpu_biu_pkg::T_FOUR) && !cyc_fetch_q && (!eu_split || part_q);
    assign part_now = (state_q == cpu_biu_pkg::T_FOUR) && !cyc_fetch_q && eu_split && !part_q ? 1'b1 : part_q;
    assign eu_off = eu_req_off_i + {15'h0000, part_now};
    // dedicated adder on the requested segment register
    assign eu_addr = phys_addr(seg_q[eu_req_seg_i], eu_off);
    assign fetch_two = WIDE && !fetch_ip_q[0];

    // execution unit accesses only through this handshake
    assign eu_req_ready_o = eu_done;

    // arbitration only at cycle boundaries, so a fetch always finishes
    always_comb begin
        // the request completing at this edge still shows valid and must not run again
        start_eu = boundary && eu_req_valid_i && !eu_done && (eu_req_write_i || rsp_count_q != 2'h2);
        start_fetch = boundary && !start_eu && !jump_i && ((QB - q_count_d) >= FETCH_FREE);
        // no wide fetch while a request waits
        if (WIDE && eu_req_valid_i) begin
            start_fetch = 1'b0;
        end
    end

    // idle when nothing wants the bus
    always_comb begin
        case (state_q)
            cpu_biu_pkg::T_IDLE: state_d = (start_eu || start_fetch) ? cpu_biu_pkg::T_ONE : cpu_biu_pkg::T_IDLE;
            cpu_biu_pkg::T_ONE: state_d = cpu_biu_pkg::T_TWO;
            cpu_biu_pkg::T_TWO: state_d = cpu_biu_pkg::T_THREE;
            cpu_biu_pkg::T_THREE: state_d = ready_q ? cpu_biu_pkg::T_FOUR : cpu_biu_pkg::T_WAIT;
            cpu_biu_pkg::T_WAIT: state_d = ready_q ? cpu_biu_pkg::T_FOUR : cpu_biu_pkg::T_WAIT;
            cpu_biu_pkg::T_FOUR: state_d = (start_eu || start_fetch) ? cpu_biu_pkg::T_ONE : cpu_biu_pkg::T_IDLE;
            default: state_d = cpu_biu_pkg::T_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= cpu_biu_pkg::T_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // cycle latch
    // ----------------------------------------
    always_comb begin
        eu_wdata_lanes = eu_req_wdata_i;
        if (part_now) begin
            eu_wdata_lanes = {eu_req_wdata_i[15:8], eu_req_wdata_i[15:8]};
        end else if (eu_split || !eu_req_word_i) begin
            eu_wdata_lanes = {eu_req_wdata_i[7:0], eu_req_wdata_i[7:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cyc_fetch_q <= 1'b0;
            cyc_write_q <= 1'b0;
            cyc_io_q <= 1'b0;
            cyc_both_q <= 1'b0;
            cyc_seg_q <= cpu_biu_pkg::SEG_CODE;
            cyc_addr_q <= '0;
            cyc_wdata_q <= 16'h0000;
        end else if (start_eu) begin
            cyc_fetch_q <= 1'b0;
            cyc_write_q <= eu_req_write_i;
            cyc_io_q <= eu_req_io_i;
            cyc_both_q <= WIDE && eu_req_word_i && !eu_split;
            cyc_seg_q <= eu_req_seg_i;
            cyc_addr_q <= eu_addr;
            cyc_wdata_q <= eu_wdata_lanes;
        end else if (start_fetch) begin
            cyc_fetch_q <= 1'b1;
            cyc_write_q <= 1'b0;
            cyc_io_q <= 1'b0;
            cyc_both_q <= fetch_two;
            cyc_seg_q <= cpu_biu_pkg::SEG_CODE;
            // fetch address on the same 20-bit adder
            cyc_addr_q <= phys_addr(seg_q[cpu_biu_pkg::SEG_CODE], fetch_ip_q);
        end
    end

    // ----------------------------------------
    // segment registers and instruction pointer
    // ----------------------------------------
    // segments and fetch pointer live here
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            seg_q <= '{default: cpu_biu_pkg::SEG_RESET};
            fetch_ip_q <= cpu_biu_pkg::IP_RESET;
        end else begin
            if (seg_wr_i) begin
                seg_q[seg_wr_sel_i] <= seg_wr_data_i;
            end
            // restart fetching at the jump target
            if (jump_i) begin
                seg_q[cpu_biu_pkg::SEG_CODE] <= jump_seg_i;
                fetch_ip_q <= jump_off_i;
            end else if (start_fetch) begin
                fetch_ip_q <= fetch_ip_q + (fetch_two ? 16'h0002 : 16'h0001);
            end
        end
    end

    // ----------------------------------------
    // prefetch queue
    // ----------------------------------------
    // a fetch already on the bus when the jump lands is dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flush_q <= 1'b0;
        end else if (jump_i && state_q != cpu_biu_pkg::T_IDLE && state_q != cpu_biu_pkg::T_FOUR) begin
            flush_q <= 1'b1;
        end else if (state_q == cpu_biu_pkg::T_FOUR) begin
            flush_q <= 1'b0;
        end
    end

    assign q_push = (state_q == cpu_biu_pkg::T_FOUR) && cyc_fetch_q && !flush_q && !jump_i;
    // head byte offered only when present; execution unit waits otherwise
    assign code_valid_o = (q_count_q != '0);
    assign code_byte_o = queue_q[q_rp_q];
    assign q_pop = code_ready_i && code_valid_o && !jump_i;
    // odd wide fetch carries only one byte
    assign push_n = q_push ? (cyc_both_q ? CW'(2) : CW'(1)) : '0;

    always_comb begin
        q_count_d = q_count_q + push_n - CW'(q_pop);
        if (jump_i) begin
            q_count_d = '0;
        end
    end

    // one storage byte per queue entry
    // first byte at the write pointer, the next one behind it
    for (genvar e = 0; e < QUEUE_BYTES; e++) begin : g_queue
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                queue_q[e] <= 8'h00;
            end else if (q_push && q_wp_q == QPW'(e)) begin
                queue_q[e] <= lane_byte;
            end else if (q_push && cyc_both_q && ptr_inc(q_wp_q) == QPW'(e)) begin
                queue_q[e] <= bus_in16[15:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || jump_i) begin
            q_wp_q <= '0;
            q_rp_q <= '0;
            q_count_q <= '0;
        end else begin
            q_count_q <= q_count_d;
            if (q_pop) begin
                q_rp_q <= ptr_inc(q_rp_q);
            end
            if (q_push) begin
                q_wp_q <= cyc_both_q ? ptr_inc(ptr_inc(q_wp_q)) : ptr_inc(q_wp_q);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            qs_q <= cpu_biu_pkg::QST_NONE;
        end else if (jump_i) begin
            qs_q <= cpu_biu_pkg::QST_FLUSH;
        end else begin
            qs_q <= q_pop ? cpu_biu_pkg::QST_TAKEN : cpu_biu_pkg::QST_NONE;
        end
    end

    // ----------------------------------------
    // execution-unit read data and its two-entry buffer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            part_q <= 1'b0;
            rdata_lo_q <= 8'h00;
        end else if (state_q == cpu_biu_pkg::T_FOUR && !cyc_fetch_q) begin
            part_q <= eu_split && !part_q;
            if (!part_q) begin
                rdata_lo_q <= lane_byte;
            end
        end
    end

    always_comb begin
        rsp_data = {8'h00, lane_byte};
        if (part_q) begin
            rsp_data = {lane_byte, rdata_lo_q};
        end else if (cyc_both_q) begin
            rsp_data = bus_in16;
        end
    end

    // reads only start with a free slot, so a stalled consumer never loses a word
    assign rsp_push = eu_done && !cyc_write_q;
    assign rsp_pop = eu_rsp_valid_o && eu_rsp_ready_i;
    assign eu_rsp_valid_o = (rsp_count_q != 2'h0);
    assign eu_rsp_rdata_o = rsp_q[rsp_rp_q];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsp_q <= '{default: 16'h0000};
            rsp_wp_q <= 1'b0;
            rsp_rp_q <= 1'b0;
            rsp_count_q <= 2'h0;
        end else begin
            if (rsp_push) begin
                rsp_q[rsp_wp_q] <= rsp_data;
                rsp_wp_q <= !rsp_wp_q;
            end
            if (rsp_pop) begin
                rsp_rp_q <= !rsp_rp_q;
            end
            rsp_count_q <= rsp_count_q + {1'b0, rsp_push} - {1'b0, rsp_pop};
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    logic in_cycle;
    logic strobe_phase;
    assign in_cycle = (state_q != cpu_biu_pkg::T_IDLE);
    assign strobe_phase = (state_q == cpu_biu_pkg::T_TWO) || (state_q == cpu_biu_pkg::T_THREE)
                          || (state_q == cpu_biu_pkg::T_WAIT);

    // address in T1, then write data or float on the same pins
    assign muxed_addr_data_o = (state_q == cpu_biu_pkg::T_ONE) ? cyc_addr_q[DATA_W-1:0] : cyc_wdata_q[DATA_W-1:0];
    assign muxed_addr_data_oe_n_o = !((state_q == cpu_biu_pkg::T_ONE) || (in_cycle && cyc_write_q));
    assign addr_mid_o = cyc_addr_q[15:8];
    // top four address bits in T1, segment status afterwards
    assign high_addr_status_o = (state_q == cpu_biu_pkg::T_ONE) ? cyc_addr_q[19:16]
                                : (in_cycle ? {2'b00, cyc_seg_q} : 4'h0);
    assign high_byte_enable_status_n_o = !(WIDE && (state_q == cpu_biu_pkg::T_ONE) && (cyc_both_q || cyc_addr_q[0]));

    // minimum-mode controls active while the strap reads high
    // released in maximum mode for the external controller
    assign min_ctl_oe_n_o = !mode_min_q;
    assign ale_o = mode_min_q && (state_q == cpu_biu_pkg::T_ONE);
    assign rd_n_o = !(strobe_phase && !cyc_write_q);
    assign wr_n_o = !(strobe_phase && cyc_write_q);
    assign mem_io_o = !cyc_io_q;
    assign dt_r_o = cyc_write_q;
    assign den_n_o = !(in_cycle && state_q != cpu_biu_pkg::T_ONE);
    assign queue_state_out_o = qs_q;

    // status code lets the external controller form commands
    always_comb begin
        cycle_status_code_o = cpu_biu_pkg::STAT_PASSIVE;
        if (!mode_min_q && in_cycle && state_q != cpu_biu_pkg::T_FOUR) begin
            if (cyc_fetch_q) begin
                cycle_status_code_o = cpu_biu_pkg::STAT_CODE;
            end else if (cyc_io_q) begin
                cycle_status_code_o = cyc_write_q ? cpu_biu_pkg::STAT_IO_WRITE : cpu_biu_pkg::STAT_IO_READ;
            end else begin
                cycle_status_code_o = cyc_write_q ? cpu_biu_pkg::STAT_MEM_WRITE : cpu_biu_pkg::STAT_MEM_READ;
            end
        end
    end

endmodule

`default_nettype wire

// file: verif/biu_check_sva.sv
`default_nettype none
// ------------------------------
// bus and queue checker
// ------------------------------
module biu_check #(
    parameter int DATA_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mode_strap_i,
    input wire logic jump_i,
    input wire logic code_valid_o,
    input wire logic code_ready_i,
    input wire logic eu_req_ready_o,
    input wire logic eu_req_write_i,
    input wire logic eu_rsp_valid_o,
    input wire logic muxed_addr_data_oe_n_o,
    input wire logic ale_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic den_n_o,
    input wire logic dt_r_o,
    input wire logic min_ctl_oe_n_o,
    input wire logic [2:0] cycle_status_code_o,
    input wire logic [1:0] queue_state_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_read_t1;
        ale_o && !dt_r_o;
    endsequence
    sequence s_write_t1;
        ale_o && dt_r_o;
    endsequence
    sequence s_pop;
        code_valid_o && code_ready_i && !jump_i;
    endsequence
    chk_addr_drive: assert property (ale_o |-> !muxed_addr_data_oe_n_o) else $error("address not driven in T1");
    chk_four_states: assert property (ale_o |=> !ale_o [*3]) else $error("bus cycle shorter than four states");
    chk_read_float: assert property (s_read_t1 |=> !rd_n_o && muxed_addr_data_oe_n_o) else $error("read T2 wrong");
    chk_write_data: assert property (s_write_t1 |=> !wr_n_o && !muxed_addr_data_oe_n_o) else $error("write T2 wrong");
    chk_done_in_t4: assert property (eu_req_ready_o |-> rd_n_o && wr_n_o && !den_n_o) else $error("done outside T4");
    chk_read_rsp: assert property (eu_req_ready_o && !eu_req_write_i |=> eu_rsp_valid_o) else $error("no read response");
    chk_jump_flush: assert property (jump_i |=> !code_valid_o && queue_state_out_o == cpu_biu_pkg::QST_FLUSH)
        else $error("jump did not flush queue");
    chk_pop_status: assert property (s_pop |=> queue_state_out_o == cpu_biu_pkg::QST_TAKEN) else $error("pop not shown");
    chk_min_mode: assert property (mode_strap_i [*5] |-> !min_ctl_oe_n_o && cycle_status_code_o == cpu_biu_pkg::STAT_PASSIVE)
        else $error("minimum mode pins wrong");
endmodule
`default_nettype wire

// file: verif/mem_model.sv
`default_nettype none
// ------------------------------
// memory on the multiplexed bus
// ------------------------------
module mem_model #(
    parameter int DATA_W = 16
) (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic den_n_i,
    input wire logic [DATA_W-1:0] bus_i,
    input wire logic [7:0] mid_i,
    input wire logic [3:0] high_i,
    output logic ready_o,
    output logic [DATA_W-1:0] bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] addr_q;
    logic [DATA_W-1:0] last_q;
    logic [DATA_W-1:0] wdata_q;
    int wait_q = 0;
    logic [7:0] base;
    // full address latched while address phase is on the pins
    always_ff @(posedge clk_i) begin
        if (ale_i) begin
            addr_q <= {high_i, mid_i, bus_i[7:0]};
            wait_q <= 6;
        end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
        end
        if (!wr_n_i) begin
            wdata_q <= bus_i;
        end
        last_q <= bus_o;
    end
    // slow: ready held low, raised for three cycles late in each cycle to outlast the pin synchroniser
    assign ready_o = !slow_i || (wait_q != 0 && wait_q < 4);
    // each lane returns the low byte of its own address; released bus toggles
    always_comb begin
        base = addr_q[7:0] & ~8'(DATA_W / 8 - 1);
        bus_o = ~last_q;
        if (!rd_n_i || (!den_n_i && wr_n_i)) begin
            for (int k = 0; k < DATA_W / 8; k++) begin
                bus_o[k*8+:8] = base + 8'(k);
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_n_i, mode_strap_i, ready_i, seg_wr_i, jump_i, code_valid_o, code_ready_i, slow;
    logic eu_req_valid_i, eu_req_ready_o, eu_req_write_i, eu_req_io_i, eu_req_word_i, eu_rsp_valid_o, eu_rsp_ready_i;
    logic muxed_addr_data_oe_n_o, high_byte_enable_status_n_o, min_ctl_oe_n_o, ale_o, rd_n_o, wr_n_o, mem_io_o, dt_r_o, den_n_o;
    logic [1:0] seg_wr_sel_i, eu_req_seg_i, queue_state_out_o;
    logic [2:0] cycle_status_code_o;
    logic [3:0] high_addr_status_o;
    logic [7:0] code_byte_o, addr_mid_o;
    logic [15:0] seg_wr_data_i, jump_seg_i, jump_off_i, eu_req_off_i, eu_req_wdata_i, eu_rsp_rdata_o;
    logic [15:0] muxed_addr_data_i, muxed_addr_data_o, mem_d;
    int err_count = 0, cmp_count = 0, cyc = 0;
    assign muxed_addr_data_i = muxed_addr_data_oe_n_o ? mem_d : muxed_addr_data_o;
    bus_interface_unit i_dut (.*);
    mem_model i_mem (.clk_i(clk_i), .slow_i(slow), .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .den_n_i(den_n_o),
        .bus_i(muxed_addr_data_i), .mid_i(addr_mid_o), .high_i(high_addr_status_o), .ready_o(ready_i), .bus_o(mem_d));
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t code byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t data word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pop(input logic [7:0] exp);
        @(negedge clk_i);
        for (int n = 0; n < 400 && code_valid_o !== 1'b1; n++) @(negedge clk_i);
        cmp_byte(code_byte_o, exp);
        @(posedge clk_i) code_ready_i <= 1'b1;
        @(posedge clk_i) code_ready_i <= 1'b0;
    endtask
    task automatic jmp(input logic [15:0] s, input logic [15:0] o);
        @(posedge clk_i) jump_i <= 1'b1;
        jump_seg_i <= s;
        jump_off_i <= o;
        @(posedge clk_i) jump_i <= 1'b0;
    endtask
    // one request held until done; reads then drain the response buffer
    task automatic eu(input logic wr, input logic [15:0] off, input logic [15:0] wd, input logic [15:0] exp);
        @(posedge clk_i) eu_req_valid_i <= 1'b1;
        eu_req_write_i <= wr;
        eu_req_off_i <= off;
        eu_req_wdata_i <= wd;
        @(negedge clk_i);
        for (int n = 0; n < 400 && eu_req_ready_o !== 1'b1; n++) @(negedge clk_i);
        @(posedge clk_i) eu_req_valid_i <= 1'b0;
        if (wr) begin
            cmp_word(i_mem.wdata_q, exp);
        end else begin
            @(negedge clk_i);
            for (int n = 0; n < 400 && eu_rsp_valid_o !== 1'b1; n++) @(negedge clk_i);
            cmp_word(eu_rsp_rdata_o, exp);
            @(posedge clk_i) eu_rsp_ready_i <= 1'b1;
            @(posedge clk_i) eu_rsp_ready_i <= 1'b0;
        end
    endtask
    task automatic t_stream;
        for (int i = 0; i < 8; i++) pop(8'(i));
        $display("test stream done");
    endtask
    task automatic t_jump;
        jmp(16'h1234, 16'h0011);
        for (int i = 0; i < 3; i++) pop(8'h51 + 8'(i));
        jmp(16'hFFFF, 16'h0021);
        pop(8'h11);
        pop(8'h12);
        $display("test jump done");
    endtask
    task automatic t_eu;
        @(posedge clk_i) seg_wr_i <= 1'b1;
        seg_wr_sel_i <= cpu_biu_pkg::SEG_DATA;
        seg_wr_data_i <= 16'h0010;
        @(posedge clk_i) seg_wr_i <= 1'b0;
        eu(1'b0, 16'h0004, 16'h0000, 16'h0504);
        @(posedge clk_i) slow <= 1'b1;
        eu(1'b0, 16'h0007, 16'h0000, 16'h0807);
        @(posedge clk_i) slow <= 1'b0;
        eu(1'b1, 16'h0008, 16'hA5C3, 16'hA5C3);
        $display("test requests done");
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // the limit is far above the roughly one hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            print_verdict;
        end
    end
    initial begin
        {rst_n_i, seg_wr_i, jump_i, code_ready_i, slow, eu_req_valid_i, eu_req_write_i, eu_rsp_ready_i} = '0;
        {seg_wr_sel_i, seg_wr_data_i, jump_seg_i, jump_off_i, eu_req_off_i, eu_req_wdata_i} = '0;
        mode_strap_i = 1'b1;
        eu_req_io_i = 1'b0;
        eu_req_word_i = 1'b1;
        eu_req_seg_i = cpu_biu_pkg::SEG_DATA;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_stream;
        t_jump;
        t_eu;
        print_verdict;
    end
endmodule
bind bus_interface_unit biu_check #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire
